// [src/mcx_pkg.sv]
// Purpose: constants and types for the machine-check / checkstop / dsi unit
// Assumes: 32-bit registers, big-endian bit numbering (bit 0 = msb)
// Notes:   register offsets are byte addresses on the avalon slave
package mcx_pkg;

   // avalon register byte offsets
   localparam logic [4:0] MCX_OFS_HWCFG    = 5'h00;
   localparam logic [4:0] MCX_OFS_SSTATE   = 5'h04;
   localparam logic [4:0] MCX_OFS_SPC      = 5'h08;
   localparam logic [4:0] MCX_OFS_MSTATE   = 5'h0C;
   localparam logic [4:0] MCX_OFS_L2CTL    = 5'h10;
   localparam logic [4:0] MCX_OFS_DBREAK   = 5'h14;
   localparam logic [4:0] MCX_OFS_STATUS   = 5'h18;
   localparam logic [4:0] MCX_OFS_FETCH    = 5'h1C;

   // big-endian bit n of a 32-bit word is little-endian index 31-n
   localparam int MCX_HW_MCIN_EN  = 31 - 0;
   localparam int MCX_HW_PGEN     = 31 - 1;
   localparam int MCX_HW_APCHK    = 31 - 2;
   localparam int MCX_HW_DPCHK    = 31 - 3;
   localparam int MCX_HW_SOFTMARK = 31 - 15;

   localparam int MCX_SS_L2DC     = 31 - 11;
   localparam int MCX_SS_MCIN     = 31 - 12;
   localparam int MCX_SS_TEA      = 31 - 13;
   localparam int MCX_SS_DPAR     = 31 - 14;
   localparam int MCX_SS_APAR     = 31 - 15;

   localparam int MCX_MS_ILE      = 31 - 15;
   localparam int MCX_MS_ME       = 31 - 19;
   localparam int MCX_MS_IP       = 31 - 25;
   localparam int MCX_MS_RI       = 31 - 30;
   localparam int MCX_MS_LE       = 31 - 31;

   // rollover checkstop enable in second-level cache control (chosen bit)
   localparam int MCX_L2_ROLL_EN  = 0;

   // breakpoint: double-word address in [31:3], data write bit 1, data read bit 0
   localparam int MCX_DB_WR       = 1;
   localparam int MCX_DB_RD       = 0;

   localparam logic [31:0] MCX_HWCFG_RST  = 32'h0000_0000;
   localparam logic [31:0] MCX_MSTATE_RST = 32'h0000_0040;
   localparam logic [31:0] MCX_ZERO32     = 32'h0000_0000;

   localparam logic [31:0] MCX_VEC_MC     = 32'h0000_0200;
   localparam logic [31:0] MCX_VEC_DSI    = 32'h0000_0300;
   localparam logic [31:0] MCX_BASE_LO    = 32'h0000_0000;
   localparam logic [31:0] MCX_BASE_HI    = 32'hFFF0_0000;

   // cycles from checkstop entry until all state is frozen
   localparam int MCX_FREEZE_CYC  = 2;

   typedef struct packed {
      logic addr_par;     // address bus parity error
      logic data_par;     // data bus parity error
      logic l1_par;       // first-level cache parity error
      logic l2_par;       // second-level data cache parity error
      logic transfer_error_ack;          // transfer error acknowledge
      logic mc_in;        // machine check input
   } mcx_err_t;

   typedef struct packed {
      logic        valid;  // data access this cycle
      logic        write;  // 1 = store
      logic        tmiss;  // translation miss, table search page fault
      logic        dstore; // segment direct-store bit
      logic [31:0] ea;     // effective address
   } mcx_dacc_t;

   typedef enum logic [1:0] {
      MCX_RUN,
      MCX_FREEZING,
      MCX_STOPPED
   } mcx_state_t;

endpackage : mcx_pkg

// [src/mcx_unit.sv]
// Purpose: machine check, checkstop and data storage exception logic
// Assumes: single clock, synchronous active-high reset, avalon-mm slave
// Notes:   all error inputs are active-high synchronous single-cycle events
`timescale 1ns/1ps
`default_nettype none

module mcx_unit
   import mcx_pkg::*;
(
   input  wire logic        clock_in,       // core clock, 200 MHz
   input  wire logic        rst_in,         // hard reset, sync, high
   input  wire mcx_err_t    err_in,         // error event sources
   input  wire logic        ext_external_checkstop_input,   // external checkstop input
   input  wire logic        dll_roll_in,    // clock dll rollover event
   input  wire mcx_dacc_t   dacc_in,        // data access from load/store
   input  wire logic [31:0] cur_pc_in,      // ea of executing instruction
   input  wire logic [4:0]  avs_address,    // byte address
   input  wire logic        avs_read,       // read request
   input  wire logic        avs_write,      // write request
   input  wire logic [31:0] avs_writedata,  // write data
   input  wire logic [3:0]  avs_byteenable, // byte lanes
   output logic [31:0]      avs_readdata,   // read data
   output logic             avs_waitrequest,// stall
   output logic             mc_take_out,    // machine check taken pulse
   output logic             dsi_take_out,   // data storage taken pulse
   output logic [31:0]      fetch_addr_out, // vector fetch address
   output logic             discard_st_out, // drop incomplete stores
   output logic             par_gen_out,    // drive bus parity
   output logic             halt_out,       // instruction processing stopped
   output logic             frozen_out      // all latches frozen
);

   logic [31:0] hwcfg_r;
   logic [31:0] sstate_r;
   logic [31:0] spc_r;
   logic [31:0] mstate_r;
   logic [31:0] l2ctl_r;
   logic [31:0] dbreak_r;
   logic [31:0] fetch_r;
   logic        mc_take_r;
   logic        dsi_take_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [1:0]  frz_cnt_r;
   mcx_state_t  state_r;

   logic        me;
   logic        a_err;
   logic        d_err;
   logic        c_err;
   logic        t_err;
   logic        m_err;
   logic        any_mc;
   logic        ckstop_req;
   logic        run;
   logic        dsi_hit;
   logic        bp_hit;
   logic [31:0] base;
   logic        wr_hit;
   logic [31:0] wmask;

   assign me  = mstate_r[MCX_MS_ME];
   assign run = (state_r == MCX_RUN);
   assign base = mstate_r[MCX_MS_IP] ? MCX_BASE_HI : MCX_BASE_LO;

   // qualified sources; cache parity and tea have no enable bit and are taken whenever seen with me set, tea imprecisely
   assign a_err = err_in.addr_par & hwcfg_r[MCX_HW_APCHK];
   assign d_err = err_in.data_par & hwcfg_r[MCX_HW_DPCHK];
   assign c_err = err_in.l1_par | err_in.l2_par;
   assign t_err = err_in.transfer_error_ack;
   assign m_err = err_in.mc_in & hwcfg_r[MCX_HW_MCIN_EN];
   assign any_mc = a_err | d_err | c_err | t_err | m_err;

   // checkstop causes
   assign ckstop_req = (any_mc & ~me)
                     | ext_external_checkstop_input
                     | (dll_roll_in & l2ctl_r[MCX_L2_ROLL_EN]);

   assign bp_hit = dacc_in.valid
                 & (dacc_in.ea[31:3] == dbreak_r[31:3])
                 & ((dacc_in.write & dbreak_r[MCX_DB_WR])
                    | (~dacc_in.write & dbreak_r[MCX_DB_RD]));
   assign dsi_hit = dacc_in.valid
                  & (dacc_in.tmiss
                     | dacc_in.dstore
                     | bp_hit);

   // write lands on the ack cycle, when waitrequest is low
   assign wr_hit = avs_write & ack_r & run;

   always_comb
   begin
      wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   end

   // checkstop sequencer; only reset leaves the stopped state
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         state_r   <= MCX_RUN;
         frz_cnt_r <= 2'h0;
      end
      else
      begin
         case (state_r)
            MCX_RUN:
            begin
               if (ckstop_req)
               begin
                  state_r   <= MCX_FREEZING;
                  frz_cnt_r <= 2'h1;
               end
            end
            MCX_FREEZING:
            begin
               if (frz_cnt_r == 2'(MCX_FREEZE_CYC - 1))
                  state_r <= MCX_STOPPED;
               else
                  frz_cnt_r <= frz_cnt_r + 2'h1;
            end
            MCX_STOPPED:
               state_r <= MCX_STOPPED;
            default:
               state_r <= MCX_STOPPED;
         endcase
      end
   end

   // hardware configuration register
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         hwcfg_r <= MCX_HWCFG_RST;
      else if (wr_hit && avs_address == MCX_OFS_HWCFG)
         hwcfg_r <= (hwcfg_r & ~wmask) | (avs_writedata & wmask);
   end

   // second-level cache control and breakpoint registers
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         l2ctl_r  <= MCX_ZERO32;
         dbreak_r <= MCX_ZERO32;
      end
      else if (wr_hit)
      begin
         if (avs_address == MCX_OFS_L2CTL)
            l2ctl_r <= (l2ctl_r & ~wmask) | (avs_writedata & wmask);
         if (avs_address == MCX_OFS_DBREAK)
            dbreak_r <= (dbreak_r & ~wmask) | (avs_writedata & wmask);
      end
   end

   // machine state, saved state, saved counter, exception entry
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         mstate_r   <= MCX_MSTATE_RST;
         sstate_r   <= MCX_ZERO32;
         spc_r      <= MCX_ZERO32;
         fetch_r    <= MCX_ZERO32;
         mc_take_r  <= 1'b0;
         dsi_take_r <= 1'b0;
      end
      else
      begin
         mc_take_r  <= 1'b0;
         dsi_take_r <= 1'b0;
         if (run && any_mc && me)
         begin
            mc_take_r <= 1'b1;
            spc_r     <= cur_pc_in;
            sstate_r  <= {11'h000,
                          err_in.l2_par,
                          m_err, t_err, d_err, a_err,
                          mstate_r[15:0]};
            mstate_r  <= (mstate_r & ((32'h1 << MCX_MS_IP)
                                      | (32'h1 << MCX_MS_ILE)))
                         | (32'(mstate_r[MCX_MS_ILE]) << MCX_MS_LE);
            fetch_r   <= base | MCX_VEC_MC;
         end
         else if (run && !ckstop_req && dsi_hit)
         begin
            dsi_take_r <= 1'b1;
            spc_r      <= cur_pc_in;
            sstate_r   <= {16'h0000, mstate_r[15:0]};
            mstate_r   <= (mstate_r & ((32'h1 << MCX_MS_IP)
                                       | (32'h1 << MCX_MS_ILE)
                                       | (32'h1 << MCX_MS_ME)))
                          | (32'(mstate_r[MCX_MS_ILE]) << MCX_MS_LE);
            fetch_r    <= base | MCX_VEC_DSI;
         end
         else if (wr_hit)
         begin
            if (avs_address == MCX_OFS_MSTATE)
               mstate_r <= (mstate_r & ~wmask) | (avs_writedata & wmask);
            if (avs_address == MCX_OFS_SSTATE)
               sstate_r <= (sstate_r & ~wmask) | (avs_writedata & wmask);
            if (avs_address == MCX_OFS_SPC)
               spc_r <= (spc_r & ~wmask) | (avs_writedata & wmask);
         end
      end
   end

   // avalon slave: one wait cycle, then ack with data
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ack_r   <= 1'b0;
         rdata_r <= MCX_ZERO32;
      end
      else
      begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         case (avs_address)
            MCX_OFS_HWCFG:  rdata_r <= hwcfg_r;
            MCX_OFS_SSTATE: rdata_r <= sstate_r;
            MCX_OFS_SPC:    rdata_r <= spc_r;
            MCX_OFS_MSTATE: rdata_r <= mstate_r;
            MCX_OFS_L2CTL:  rdata_r <= l2ctl_r;
            MCX_OFS_DBREAK: rdata_r <= dbreak_r;
            MCX_OFS_STATUS: rdata_r <= {30'h0, ~run,
                                        state_r == MCX_STOPPED};
            MCX_OFS_FETCH:  rdata_r <= fetch_r;
            default:        rdata_r <= MCX_ZERO32;
         endcase
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign mc_take_out     = mc_take_r;
   assign dsi_take_out    = dsi_take_r;
   assign fetch_addr_out  = fetch_r;
   assign discard_st_out  = mc_take_r;
   assign par_gen_out     = hwcfg_r[MCX_HW_PGEN];
   assign halt_out        = ~run;
   assign frozen_out      = (state_r == MCX_STOPPED);

endmodule : mcx_unit

`default_nettype wire

// [test/mcx_unit_assertions.sv]
// Purpose: port-level checks of the machine check unit
// Assumes: one clock, sync active-high reset
// Notes:   bound to every mcx_unit instance
`timescale 1ns/1ps
`default_nettype none
module mcx_unit_assertions
   import mcx_pkg::*;
(
   input wire logic        clock_in,       // core clock
   input wire logic        rst_in,         // sync reset
   input wire logic        ext_external_checkstop_input,   // checkstop input
   input wire logic [4:0]  avs_address,    // byte address
   input wire logic        avs_write,      // write request
   input wire logic        avs_waitrequest,// stall
   input wire logic        mc_take_out,    // machine check pulse
   input wire logic        dsi_take_out,   // data storage pulse
   input wire logic [31:0] fetch_addr_out, // vector address
   input wire logic        discard_st_out, // store discard
   input wire logic        par_gen_out,    // parity generate
   input wire logic        halt_out,       // halted
   input wire logic        frozen_out      // frozen
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   mc_discard_a: assert property (
      mc_take_out |-> discard_st_out)
      else $error("store discard missing");
   mc_vector_a: assert property (
      mc_take_out |-> fetch_addr_out[11:0] == 12'h200)
      else $error("machine check vector wrong");
   dsi_vector_a: assert property (
      dsi_take_out |-> fetch_addr_out[11:0] == 12'h300)
      else $error("data storage vector wrong");
   freeze_delay_a: assert property (
      $rose(halt_out) |-> !frozen_out ##1 frozen_out)
      else $error("freeze delay wrong");
   halt_hold_a: assert property (
      halt_out |=> halt_out)
      else $error("halt released before reset");
   ckstp_halt_a: assert property (
      ext_external_checkstop_input |=> halt_out)
      else $error("checkstop input ignored");
   stop_quiet_a: assert property (
      frozen_out |-> !mc_take_out && !dsi_take_out)
      else $error("exception while stopped");
   pgen_write_a: assert property (
      $changed(par_gen_out) |->
         $past(avs_write && !avs_waitrequest && avs_address == MCX_OFS_HWCFG))
      else $error("parity generate changed without write");
   bus_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state too long");
endmodule : mcx_unit_assertions

bind mcx_unit mcx_unit_assertions u_chk (.clock_in(clock_in), .rst_in(rst_in),
   .ext_external_checkstop_input(ext_external_checkstop_input), .avs_address(avs_address),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .mc_take_out(mc_take_out), .dsi_take_out(dsi_take_out),
   .fetch_addr_out(fetch_addr_out), .discard_st_out(discard_st_out),
   .par_gen_out(par_gen_out), .halt_out(halt_out), .frozen_out(frozen_out));
`default_nettype wire

// [test/mcx_mem_ctl.sv]
// Purpose: memory controller model that flags failing bus operations
// Assumes: one access request per cycle, fault marks bad ecc or parity
// Notes:   transfer error is a one-cycle pulse, low otherwise
`timescale 1ns/1ps
`default_nettype none
module mcx_mem_ctl
(
   input  wire logic clock_in, // core clock
   input  wire logic rst_in,   // sync reset
   input  wire logic req_in,   // load or store on the bus
   input  wire logic fault_in, // memory parity or ecc fault
   output var  logic tea_out   // transfer error acknowledge
);
   always_ff @(posedge clock_in)
      tea_out <= !rst_in && req_in && fault_in;
endmodule : mcx_mem_ctl
`default_nettype wire

// [test/mcx_unit_tb.sv]
// Purpose: self-checking bench of the machine check unit
// Assumes: one wait state on the register bus
// Notes:   expected reads and vectors are queued by the driver
`timescale 1ns/1ps
`default_nettype none
module mcx_unit_tb
   import mcx_pkg::*;
;
   logic        clock_in, rst_in, ext_ckstp, dll_roll, mreq, mfault, tea_w;
   logic        avs_read, avs_write, wreq, mc, dsi, disc, pgen, halt, frz;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, cur_pc, rnd, rdata, faddr;
   mcx_err_t    errb, err;
   mcx_dacc_t   dacc;
   int          n_mismatch, num_checks;
   logic [31:0] rq[$], fq[$];

   assign err = {errb[5:2], tea_w, errb[0]};

   mcx_mem_ctl u_mem (.clock_in(clock_in), .rst_in(rst_in), .req_in(mreq),
      .fault_in(mfault), .tea_out(tea_w));
   mcx_unit DUT (.clock_in(clock_in), .rst_in(rst_in), .err_in(err),
      .ext_external_checkstop_input(ext_ckstp), .dll_roll_in(dll_roll), .dacc_in(dacc),
      .cur_pc_in(cur_pc), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .mc_take_out(mc), .dsi_take_out(dsi), .fetch_addr_out(faddr),
      .discard_st_out(disc), .par_gen_out(pgen), .halt_out(halt),
      .frozen_out(frz));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask : cyc

   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clock_in);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      @(posedge clock_in);
      while (wreq !== 1'b0)
         @(posedge clock_in);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic ev(input logic [5:0] e, input logic d, x);
      @(posedge clock_in);
      errb      <= e;
      dll_roll  <= d;
      ext_ckstp <= x;
      @(posedge clock_in);
      errb      <= '0;
      dll_roll  <= 1'b0;
      ext_ckstp <= 1'b0;
      cyc(3);
   endtask : ev

   task automatic do_rst;
      rst_in <= 1'b1;
      cyc(16);
      rst_in <= 1'b0;
   endtask : do_rst

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   always @(negedge clock_in)
   begin
      if (avs_read && wreq === 1'b0)
         chk("readdata", rdata, rq.size() ? rq.pop_front() : 32'hDEAD_BEEF);
      if (mc === 1'b1 || dsi === 1'b1)
         chk("fetch", faddr, fq.size() ? fq.pop_front() : 32'hDEAD_BEEF);
   end

   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   initial
   begin
      cyc(3000);
      n_mismatch++;
      complete_run;
   end

   initial
   begin
      {ext_ckstp, dll_roll, mreq, mfault, avs_read, avs_write} = '0;
      rst_in = 1'b1;
      {errb, dacc, avs_address, avs_writedata, cur_pc} = '0;
      rnd = 32'h33;
      do_rst;
      rd(MCX_OFS_HWCFG, 32'h0);
      rd(MCX_OFS_MSTATE, 32'h0000_0040);
      bus(1'b1, MCX_OFS_HWCFG, 32'h7001_0000);
      rd(MCX_OFS_HWCFG, 32'h7001_0000);
      chk("pgen", {31'h0, pgen}, 32'h1);
      ev(6'h01, 1'b0, 1'b0);
      chk("halt", {31'h0, halt}, 32'h0);
      $display("test config done");
      bus(1'b1, MCX_OFS_MSTATE, 32'h0000_1040);
      rnd = lfsr(rnd);
      fq.push_back(32'hFFF0_0200);
      @(posedge clock_in);
      {cur_pc, mreq, mfault} <= {rnd, 2'h3};
      @(posedge clock_in);
      {mreq, mfault} <= 2'h0;
      cyc(4);
      rd(MCX_OFS_SSTATE, 32'h0004_1040);
      rd(MCX_OFS_SPC, rnd);
      rd(MCX_OFS_MSTATE, 32'h0000_0040);
      chk("discard", {31'h0, disc}, 32'h0);
      $display("test machine check done");
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         if (i == 0)
            bus(1'b1, MCX_OFS_DBREAK, {rnd[31:3], 3'h1});
         fq.push_back(32'hFFF0_0300);
         @(posedge clock_in);
         dacc <= '{1'b1, i != 0, i == 2, i == 1, rnd};
         @(posedge clock_in);
         dacc <= '0;
         cyc(3);
      end
      $display("test data storage done");
      ev(6'h10, 1'b0, 1'b0);
      chk("frozen", {30'h0, halt, frz}, 32'h3);
      bus(1'b1, MCX_OFS_HWCFG, 32'h0);
      rd(MCX_OFS_HWCFG, 32'h7001_0000);
      rd(MCX_OFS_STATUS, 32'h3);
      $display("test checkstop done");
      do_rst;
      rd(MCX_OFS_HWCFG, 32'h0);
      ev(6'h00, 1'b1, 1'b0);
      chk("roll off", {31'h0, halt}, 32'h0);
      bus(1'b1, MCX_OFS_L2CTL, 32'h1);
      ev(6'h00, 1'b1, 1'b0);
      chk("roll on", {31'h0, halt}, 32'h1);
      do_rst;
      ev(6'h00, 1'b0, 1'b1);
      chk("ext stop", {31'h0, halt}, 32'h1);
      $display("test stop sources done");
      complete_run;
   end
endmodule : mcx_unit_tb
`default_nettype wire
